/* hdl/mbpwm_top.sv */
// match based pwm timer: 32 bit prescaler, counter, seven shadowed matches
// assumes one clock, synchronous low reset, capture pins asynchronous
`timescale 1ns/1ps
//Contract
//- period match resets count, new cycle
//- single edge output uses one match
//- single edge outputs rise at cycle start
//- constant low output never rises
//- double edge uses rise and fall match
//- edge order gives positive or negative pulse
//- seven matches, six single, five double
//- match may interrupt, stop or reset
//- timer or capture pin counter mode
//- 32 bit counter with 32 bit prescaler
//- any counts, shared repetition rate
//- matches apply only after release, at cycle end while running in pwm mode
//- pwm disabled means plain timer
//- master slave synchronised start
module mbpwm_top (
  input  wire logic                               i_clk,
  input  wire logic                               i_resetn,
  input  wire logic                               i_ce,
  input  wire mbpwm_pkg::mbpwm_req_t              i_req,
  output logic [31:0]                             o_rdata,
  input  wire logic [1:0]                         i_cap,
  input  wire logic                               i_sync_start,
  output logic                                    o_sync_start,
  output logic [mbpwm_pkg::NUM_OUT-1:0]           o_pwm,
  output logic [mbpwm_pkg::NUM_OUT-1:0]           o_pwm_oe,
  output logic                                    o_irq
);
  localparam int unsigned NM = mbpwm_pkg::NUM_MATCH;
  localparam int unsigned NO = mbpwm_pkg::NUM_OUT;
  // every output needs its own match beside the period match
  if (NM != NO + 1) begin
    $error("match count must be outputs plus one");
  end
  // all match words must fit below the top of the address space
  if (int'(mbpwm_pkg::OFF_MATCH0) + NM * int'(mbpwm_pkg::OFF_STEP) >
      (1 << mbpwm_pkg::ADDR_W)) begin
    $error("match words exceed the address space");
  end

  // ==========================================================
  // registers
  logic [6:0]        ctrl_q;
  logic [31:0]       prescl_q;
  logic [31:0]       count_q;
  logic [31:0]       precnt_q;
  logic [3*NM-1:0]   mctrl_q;
  logic [15:0]       outcfg_q;
  logic [NM-1:0]     pend_q;
  logic [NM-1:0]     status_q;
  logic [NM-1:0]     inten_q;
  logic [31:0]       shadow_q [NM];
  logic [31:0]       match_q  [NM];
  logic [NO-1:0]     pwm_q;
  logic [31:0]       rdata_q;
  logic [1:0]        cap_s1_q;
  logic [1:0]        cap_s2_q;
  logic [1:0]        cap_s3_q;
  logic              sync_s1_q;
  logic              sync_s2_q;

  logic              wr_ctrl;
  logic              wr_release;
  logic              wr_clr;
  logic              wr_prescl;
  logic              wr_mctrl;
  logic              wr_outcfg;
  logic              wr_inten;
  logic [NM-1:0]     wr_match;
  logic              tick;
  logic              cap_edge;
  logic [NM-1:0]     hit;
  logic              period_end;
  logic              stop_hit;
  logic              rst_hit;
  logic              running;

  assign wr_ctrl    = i_req.wr && (i_req.addr == mbpwm_pkg::OFF_CTRL);
  assign wr_release = i_req.wr && (i_req.addr == mbpwm_pkg::OFF_RELEASE);
  assign wr_clr     = i_req.wr && (i_req.addr == mbpwm_pkg::OFF_INTCLR);
  assign wr_prescl  = i_req.wr && (i_req.addr == mbpwm_pkg::OFF_PRESCL);
  assign wr_mctrl   = i_req.wr && (i_req.addr == mbpwm_pkg::OFF_MCTRL);
  assign wr_outcfg  = i_req.wr && (i_req.addr == mbpwm_pkg::OFF_OUTCFG);
  assign wr_inten   = i_req.wr && (i_req.addr == mbpwm_pkg::OFF_INTEN);

  always_comb begin
    for (int k = 0; k < NM; k++) begin
      wr_match[k] = i_req.wr &&
        (i_req.addr == mbpwm_pkg::OFF_MATCH0 + 7'(k) * mbpwm_pkg::OFF_STEP);
    end
  end

  // ==========================================================
  // input synchronisers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cap_s1_q  <= 2'h0;
      cap_s2_q  <= 2'h0;
      cap_s3_q  <= 2'h0;
    end else if (i_ce) begin
      cap_s1_q  <= i_cap;
      cap_s2_q  <= cap_s1_q;
      cap_s3_q  <= cap_s2_q;
    end
  end
  // master start strobe comes from another instance
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sync_s1_q <= 1'h0;
      sync_s2_q <= 1'h0;
    end else if (i_ce) begin
      sync_s1_q <= i_sync_start;
      sync_s2_q <= sync_s1_q;
    end
  end

  // ==========================================================
  // count source and prescaler
  logic csel;
  assign csel     = ctrl_q[mbpwm_pkg::CTRL_CSEL];
  assign cap_edge = cap_s2_q[csel] && !cap_s3_q[csel];
  // slave waits for the master's start strobe
  assign running  = ctrl_q[mbpwm_pkg::CTRL_RUN] && !ctrl_q[mbpwm_pkg::CTRL_CRST] &&
                    (!ctrl_q[mbpwm_pkg::CTRL_SLAVE] || sync_s2_q);
  logic src_en;
  assign src_en = ctrl_q[mbpwm_pkg::CTRL_CNTM] ? cap_edge : 1'b1;
  // lowering the prescale mid-count must not wrap the prescaler
  assign tick   = running && src_en && (precnt_q >= prescl_q);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      precnt_q <= mbpwm_pkg::RST_WORD;
    end else if (i_ce) begin
      if (ctrl_q[mbpwm_pkg::CTRL_CRST] || tick) begin
        precnt_q <= mbpwm_pkg::RST_WORD;
      end else if (running && src_en) begin
        precnt_q <= precnt_q + 32'h1;
      end
    end
  end

  // ==========================================================
  // match compare, evaluated on each tick
  always_comb begin
    for (int k = 0; k < NM; k++) begin
      hit[k] = tick && (count_q == match_q[k]);
    end
  end
  always_comb begin
    stop_hit = 1'b0;
    rst_hit  = 1'b0;
    for (int k = 0; k < NM; k++) begin
      stop_hit = stop_hit | (hit[k] & mctrl_q[3*k+mbpwm_pkg::MC_STOP]);
      rst_hit  = rst_hit  | (hit[k] & mctrl_q[3*k+mbpwm_pkg::MC_RST]);
    end
  end
  // in pwm mode the period match always ends the cycle
  assign period_end = rst_hit ||
    (ctrl_q[mbpwm_pkg::CTRL_PWMEN] && hit[0]);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count_q <= mbpwm_pkg::RST_WORD;
    end else if (i_ce) begin
      if (ctrl_q[mbpwm_pkg::CTRL_CRST]) begin
        count_q <= mbpwm_pkg::RST_WORD;
      end else if (period_end) begin
        count_q <= mbpwm_pkg::RST_WORD;
      end else if (tick) begin
        count_q <= count_q + 32'h1;
      end
    end
  end

  // ==========================================================
  // control, configuration, stop action
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl_q <= 7'h00;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        ctrl_q <= i_req.wdata[6:0];
      end else if (stop_hit) begin
        ctrl_q[mbpwm_pkg::CTRL_RUN] <= 1'b0;
      end
    end
  end
  // configuration words, each written whole
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      prescl_q <= mbpwm_pkg::RST_WORD;
      mctrl_q  <= '0;
      outcfg_q <= 16'h0000;
      inten_q  <= '0;
    end else if (i_ce) begin
      if (wr_prescl) begin
        prescl_q <= i_req.wdata;
      end
      if (wr_mctrl) begin
        mctrl_q <= i_req.wdata[3*NM-1:0];
      end
      if (wr_outcfg) begin
        outcfg_q <= i_req.wdata[15:0];
      end
      if (wr_inten) begin
        inten_q <= i_req.wdata[NM-1:0];
      end
    end
  end

  // ==========================================================
  // shadowed match values
  logic reload;
  // while stopped or not in pwm mode, released values apply at once
  assign reload = !ctrl_q[mbpwm_pkg::CTRL_PWMEN] || !running || period_end;

  // active value each match holds after this edge
  logic [31:0] next_match [NM];
  always_comb begin
    for (int k = 0; k < NM; k++) begin
      next_match[k] = (pend_q[k] && reload) ? shadow_q[k] : match_q[k];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      for (int k = 0; k < NM; k++) begin
        shadow_q[k] <= mbpwm_pkg::RST_WORD;
      end
    end else if (i_ce) begin
      for (int k = 0; k < NM; k++) begin
        if (wr_match[k]) begin
          shadow_q[k] <= i_req.wdata;
        end
      end
    end
  end
  // active values follow the shadows only at a reload
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      for (int k = 0; k < NM; k++) begin
        match_q[k] <= mbpwm_pkg::RST_WORD;
      end
    end else if (i_ce) begin
      for (int k = 0; k < NM; k++) begin
        match_q[k] <= next_match[k];
      end
    end
  end
  // release arriving with a reload stays pending for next time
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pend_q <= '0;
    end else if (i_ce) begin
      if (wr_release) begin
        pend_q <= pend_q | i_req.wdata[NM-1:0];
      end else if (reload) begin
        pend_q <= '0;
      end
    end
  end

  // ==========================================================
  // pwm outputs
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pwm_q <= '0;
    end else if (i_ce) begin
      for (int n = 1; n <= NO; n++) begin
        if (outcfg_q[mbpwm_pkg::OC_DBL+n-1] && n >= 2) begin
          // double edge: match n-1 rises, match n falls
          if (hit[n]) begin
            pwm_q[n-1] <= 1'b0;
          end else if (hit[n-1]) begin
            pwm_q[n-1] <= 1'b1;
          end
        end else begin
          // a zero match keeps the output low all cycle
          if (hit[n]) begin
            pwm_q[n-1] <= 1'b0;
          end else if (period_end && next_match[n] != 32'h0) begin
            pwm_q[n-1] <= 1'b1;
          end
        end
      end
    end
  end
  // pins driven only in pwm mode
  assign o_pwm_oe = ctrl_q[mbpwm_pkg::CTRL_PWMEN] ?
    outcfg_q[mbpwm_pkg::OC_EN+NO-1:mbpwm_pkg::OC_EN] : '0;
  assign o_pwm    = pwm_q & o_pwm_oe;
  assign o_sync_start = ctrl_q[mbpwm_pkg::CTRL_RUN] && !ctrl_q[mbpwm_pkg::CTRL_CRST];

  // ==========================================================
  // interrupt status, set wins over clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      status_q <= '0;
    end else if (i_ce) begin
      for (int k = 0; k < NM; k++) begin
        if (hit[k] && mctrl_q[3*k+mbpwm_pkg::MC_INT]) begin
          status_q[k] <= 1'b1;
        end else if (wr_clr && i_req.wdata[k]) begin
          status_q[k] <= 1'b0;
        end
      end
    end
  end
  assign o_irq = |(status_q & inten_q);

  // ==========================================================
  // read port
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_q <= mbpwm_pkg::RST_WORD;
    end else if (i_ce) begin
      rdata_q <= mbpwm_pkg::RST_WORD;
      if (i_req.rd) begin
        unique case (i_req.addr)
          mbpwm_pkg::OFF_CTRL:   rdata_q <= {25'h0, ctrl_q};
          mbpwm_pkg::OFF_PRESCL: rdata_q <= prescl_q;
          mbpwm_pkg::OFF_COUNT:  rdata_q <= count_q;
          mbpwm_pkg::OFF_PRECNT: rdata_q <= precnt_q;
          mbpwm_pkg::OFF_MCTRL:  rdata_q <= {11'h0, mctrl_q};
          mbpwm_pkg::OFF_OUTCFG: rdata_q <= {16'h0, outcfg_q};
          mbpwm_pkg::OFF_RELEASE: rdata_q <= {25'h0, pend_q};
          mbpwm_pkg::OFF_STATUS: rdata_q <= {25'h0, status_q};
          mbpwm_pkg::OFF_INTEN:  rdata_q <= {25'h0, inten_q};
          default: begin
            for (int k = 0; k < NM; k++) begin
              if (i_req.addr == mbpwm_pkg::OFF_MATCH0 + 7'(k) * mbpwm_pkg::OFF_STEP) begin
                rdata_q <= shadow_q[k];
              end
            end
          end
        endcase
      end
    end
  end
  assign o_rdata = rdata_q;
endmodule

/* shared/mbpwm_pkg.sv */
// package for the match based pwm timer: register map, field layout, types
// assumes a single 25 MHz clock and a plain strobe register port
package mbpwm_pkg;
  localparam int unsigned NUM_MATCH  = 7;
  localparam int unsigned NUM_OUT    = 6;
  localparam int unsigned ADDR_W     = 7;
  // ==========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 7'h00;
  localparam logic [ADDR_W-1:0] OFF_PRESCL  = 7'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT   = 7'h08;
  localparam logic [ADDR_W-1:0] OFF_PRECNT  = 7'h0C;
  localparam logic [ADDR_W-1:0] OFF_MCTRL   = 7'h10;
  localparam logic [ADDR_W-1:0] OFF_OUTCFG  = 7'h14;
  localparam logic [ADDR_W-1:0] OFF_RELEASE = 7'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 7'h1C;
  localparam logic [ADDR_W-1:0] OFF_INTCLR  = 7'h20;
  localparam logic [ADDR_W-1:0] OFF_INTEN   = 7'h24;
  localparam logic [ADDR_W-1:0] OFF_MATCH0  = 7'h28;
  localparam logic [ADDR_W-1:0] OFF_STEP    = 7'h04;
  // ==========================================================
  // control register bits
  localparam int unsigned CTRL_RUN   = 0;
  localparam int unsigned CTRL_CRST  = 1;
  localparam int unsigned CTRL_PWMEN = 2;
  localparam int unsigned CTRL_CNTM  = 3;
  localparam int unsigned CTRL_CSEL  = 4;
  localparam int unsigned CTRL_SLAVE = 6;
  // match control: three bits per match: int, reset, stop
  localparam int unsigned MC_INT     = 0;
  localparam int unsigned MC_RST     = 1;
  localparam int unsigned MC_STOP    = 2;
  // output config: bits 5:0 output enable, bits 13:9 double edge select, bit 8 unused
  localparam int unsigned OC_EN      = 0;
  localparam int unsigned OC_DBL     = 8;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } mbpwm_req_t;
endpackage

/* test/mbpwm_chk.sv */
// port checker for the match based pwm timer
// assumes it is bound into mbpwm_top
`timescale 1ns/1ps
module mbpwm_chk (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_ce,
  input  wire mbpwm_pkg::mbpwm_req_t i_req,
  input  wire logic [31:0]           o_rdata,
  input  wire logic                  o_sync_start,
  input  wire logic [5:0]            o_pwm,
  input  wire logic [5:0]            o_pwm_oe,
  input  wire logic                  o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic ctl_wr;
  assign ctl_wr = i_ce && i_req.wr && i_req.addr == mbpwm_pkg::OFF_CTRL;
  // ====
  // bus and pins
  rd_idle_a: assert property ($past(i_ce) && !$past(i_req.rd) |-> o_rdata == 32'h0)
    else $error("read data not idle");
  // enables expected from what software last wrote
  logic       pwmen_q;
  logic [5:0] oen_q;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pwmen_q <= 1'b0;
      oen_q   <= 6'h00;
    end else if (i_ce && i_req.wr) begin
      if (i_req.addr == mbpwm_pkg::OFF_CTRL) begin
        pwmen_q <= i_req.wdata[mbpwm_pkg::CTRL_PWMEN];
      end
      if (i_req.addr == mbpwm_pkg::OFF_OUTCFG) begin
        oen_q <= i_req.wdata[5:0];
      end
    end
  end
  pin_gate_a: assert property (o_pwm_oe == (pwmen_q ? oen_q : 6'h00))
    else $error("pin enables differ from programming");
  rst_quiet_a: assert property ($past(!i_resetn) |-> o_pwm_oe == 6'h00 && !o_irq)
    else $error("outputs active after reset");
  sync_follow_a: assert property (ctl_wr |=> o_sync_start ==
    ($past(i_req.wdata[mbpwm_pkg::CTRL_RUN]) && !$past(i_req.wdata[mbpwm_pkg::CTRL_CRST])))
    else $error("sync start wrong");
  plain_off_a: assert property (ctl_wr && !i_req.wdata[mbpwm_pkg::CTRL_PWMEN]
    |=> o_pwm_oe == 6'h00) else $error("enables set in timer mode");
  irq_mask_a: assert property (i_ce && i_req.wr && i_req.addr == mbpwm_pkg::OFF_INTEN
    && i_req.wdata[6:0] == 7'h00 |=> !o_irq) else $error("irq with all masked");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(i_ce && i_req.wr))
    else $error("irq dropped without write");
  oe_write_a: assert property (!$stable(o_pwm_oe) |-> $past(i_ce && i_req.wr))
    else $error("enables moved without write");
  ce_hold_a: assert property (!$past(i_ce) |->
    $stable(o_pwm) && $stable(o_irq) && $stable(o_rdata)) else $error("moved while frozen");
endmodule
bind mbpwm_top mbpwm_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_req(i_req),
  .o_rdata(o_rdata), .o_sync_start(o_sync_start), .o_pwm(o_pwm), .o_pwm_oe(o_pwm_oe),
  .o_irq(o_irq));

/* test/mbpwm_load.sv */
// external load on the pwm pins
// assumes pin levels and enables from mbpwm_top
`timescale 1ns/1ps
module mbpwm_load (
  input  wire logic [5:0] i_pwm,
  input  wire logic [5:0] i_oe,
  output logic [5:0]      o_line
);
  // undriven pins fall to the pull-down
  assign o_line = i_pwm & i_oe;
endmodule

/* test/tb_top.sv */
// self-checking bench for the match based pwm timer
// assumes mbpwm_top, mbpwm_load and the bound checker
`timescale 1ns/1ps
module tb_top;
  localparam logic [6:0] M0 = mbpwm_pkg::OFF_MATCH0;
  logic                  i_clk = 1'b0;
  logic                  i_resetn = 1'b0;
  logic                  i_ce = 1'b1;
  mbpwm_pkg::mbpwm_req_t req = '0;
  logic [1:0]            cap = 2'h0;
  logic                  sync = 1'b0;
  logic                  sync_o;
  logic                  irq;
  logic [31:0]           rdata;
  logic [31:0]           v;
  logic [31:0]           w;
  logic [5:0]            pwm;
  logic [5:0]            oe;
  logic [5:0]            line;
  int                    error_cnt = 0;
  int                    num_checks = 0;
  int                    p, d, r, f, n;
  int                    hi[6];
  int                    rs[6];
  always #20 i_clk = ~i_clk;
  mbpwm_top uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_req(req), .o_rdata(rdata),
    .i_cap(cap), .i_sync_start(sync), .o_sync_start(sync_o), .o_pwm(pwm), .o_pwm_oe(oe),
    .o_irq(irq));
  mbpwm_load load (.i_pwm(pwm), .i_oe(oe), .o_line(line));
  // ====
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic bus_wr(input logic [6:0] a, input logic [31:0] dt);
    @(posedge i_clk);
    req <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    req <= '0;
  endtask
  task automatic bus_rd(input logic [6:0] a, output logic [31:0] dt);
    @(posedge i_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    req <= '0;
    @(negedge i_clk);
    dt = rdata;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  // high cycles and rising edges per pin over c cycles
  task automatic meas(input int c);
    logic [5:0] prev;
    @(negedge i_clk);
    prev = line;
    for (int k = 0; k < 6; k++) begin
      hi[k] = 0;
      rs[k] = 0;
    end
    repeat (c) begin
      @(negedge i_clk);
      for (int k = 0; k < 6; k++) begin
        hi[k] += line[k];
        rs[k] += line[k] & ~prev[k];
      end
      prev = line;
    end
  endtask
  function automatic int dbl_w(int rr, int ff, int pp);
    return (ff - rr + pp + 1) % (pp + 1);
  endfunction
  // ====
  // sequence
  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h664f));
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    bus_rd(mbpwm_pkg::OFF_CTRL, v);
    chk(v, 32'h0);
    bus_rd(mbpwm_pkg::OFF_STATUS, v);
    chk(v, 32'h0);
    bus_rd(7'h7C, v);
    chk(v, 32'h0);
    p = 4 + $urandom % 8;
    d = 1 + $urandom % (p - 1);
    bus_wr(M0, p);
    bus_wr(M0 + 6'h04, d);
    bus_wr(M0 + 6'h14, 0);
    bus_wr(mbpwm_pkg::OFF_OUTCFG, 32'h415);
    bus_wr(mbpwm_pkg::OFF_RELEASE, 32'h23);
    bus_wr(mbpwm_pkg::OFF_CTRL, 32'h5);
    for (int k = 0; k < 3; k++) begin
      r = (k == 1) ? p - 1 : 1;
      f = (k == 1) ? 1 : p - 1;
      bus_wr(mbpwm_pkg::OFF_PRESCL, k);
      bus_wr(M0 + 6'h08, r);
      bus_wr(M0 + 6'h0C, f);
      bus_wr(mbpwm_pkg::OFF_RELEASE, 32'h0C);
      idle(3 * (p + 1) * (k + 1));
      meas(4 * (p + 1) * (k + 1));
      chk(rs[0], 4);
      chk(hi[0], 4 * (d + 1) * (k + 1));
      chk(rs[2], 4);
      chk(hi[2], 4 * dbl_w(r, f, p) * (k + 1));
      chk(hi[4], 0);
      chk(oe, 6'h15);
    end
    bus_wr(mbpwm_pkg::OFF_PRESCL, 0);
    n = d % (p - 1) + 1;
    bus_wr(M0 + 6'h04, n);
    idle(2 * (p + 1));
    meas(4 * (p + 1));
    chk(hi[0], 4 * (d + 1));
    bus_wr(mbpwm_pkg::OFF_RELEASE, 32'h2);
    idle(2 * (p + 1));
    meas(4 * (p + 1));
    chk(hi[0], 4 * (n + 1));
    bus_wr(mbpwm_pkg::OFF_CTRL, 32'h2);
    bus_wr(mbpwm_pkg::OFF_MCTRL, 32'h3);
    bus_wr(mbpwm_pkg::OFF_INTEN, 32'h1);
    bus_wr(mbpwm_pkg::OFF_CTRL, 32'h1);
    @(negedge i_clk);
    chk(oe, 6'h00);
    n = 0;
    while (irq !== 1'b1) begin
      @(negedge i_clk);
      n++;
      if (n > 100) begin
        error_cnt++;
        finish_test();
      end
    end
    bus_rd(mbpwm_pkg::OFF_STATUS, v);
    chk(v[0], 1'b1);
    bus_wr(mbpwm_pkg::OFF_INTEN, 32'h0);
    @(negedge i_clk);
    chk(irq, 1'b0);
    bus_wr(mbpwm_pkg::OFF_MCTRL, 32'h5);
    idle(2 * (p + 1));
    bus_rd(mbpwm_pkg::OFF_COUNT, v);
    bus_rd(mbpwm_pkg::OFF_COUNT, w);
    chk(w, v);
    chk(sync_o, 1'b0);
    bus_wr(mbpwm_pkg::OFF_INTCLR, 32'h1);
    bus_wr(mbpwm_pkg::OFF_INTEN, 32'h1);
    bus_rd(mbpwm_pkg::OFF_STATUS, v);
    chk(v, 32'h0);
    chk(irq, 1'b0);
    bus_wr(mbpwm_pkg::OFF_MCTRL, 32'h0);
    bus_wr(mbpwm_pkg::OFF_CTRL, 32'h2);
    bus_wr(mbpwm_pkg::OFF_CTRL, 32'h9);
    repeat (5) begin
      cap <= 2'h1;
      idle(3);
      cap <= 2'h0;
      idle(3);
    end
    bus_rd(mbpwm_pkg::OFF_COUNT, v);
    chk(v, 32'h5);
    bus_wr(mbpwm_pkg::OFF_CTRL, 32'h2);
    bus_wr(mbpwm_pkg::OFF_CTRL, 32'h19);
    for (int k = 0; k < 5; k++) begin
      cap <= (k < 3) ? 2'h2 : 2'h1;
      idle(3);
      cap <= 2'h0;
      idle(3);
    end
    bus_rd(mbpwm_pkg::OFF_COUNT, v);
    chk(v, 32'h3);
    bus_wr(mbpwm_pkg::OFF_CTRL, 32'h2);
    bus_wr(mbpwm_pkg::OFF_CTRL, 32'h41);
    @(negedge i_clk);
    chk(sync_o, 1'b1);
    idle(10);
    bus_rd(mbpwm_pkg::OFF_COUNT, v);
    chk(v, 32'h0);
    @(posedge i_clk);
    sync <= 1'b1;
    i_ce <= 1'b0;
    idle(4);
    i_ce <= 1'b1;
    idle(10);
    bus_rd(mbpwm_pkg::OFF_COUNT, v);
    chk(v != 32'h0, 1'b1);
    finish_test();
  end
endmodule
